//--- clock_divider.sv
// Divide-by-two toggle stage for the base clock output
module clock_divider (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hold,
    output logic half
);
    // Hold forces the output low and restarts the phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half <= 1'b0;
        end else if (hold) begin
            half <= 1'b0;
        end else begin
            half <= ~half;
        end
    end
endmodule

//--- pll_clock_asserts.sv
// Concurrent checks on the ports of the clock control block
`include "pll_clock_params.svh"

module pll_clock_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic stop_req,
    input wire logic crystal_clock_out,
    input wire logic base_clock_out,
    input wire logic timing_interrupt_clock,
    input wire logic stopped
);
    // ****************************************************************
    // Sequences and properties
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    // Two stopped cycles give the outputs their one cycle to settle
    sequence stop_settled;
        stopped [*2];
    endsequence

    stop_enter_a: assert property (stop_req |=> stopped)
        else $error("stop request did not enter stop");
    stop_quiet_a: assert property (stop_settled |->
        !crystal_clock_out && !base_clock_out && !timing_interrupt_clock)
        else $error("clock output active in stop");
    write_answer_a: assert property (both_taken |-> ##[1:2] bvalid)
        else $error("write response missing");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data missing");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    read_refuse_a: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
    write_refuse_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
endmodule

bind pll_clock_stop_break_lock pll_clock_asserts chk (.clk(clk), .nrst(nrst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .stop_req(stop_req), .crystal_clock_out(crystal_clock_out),
    .base_clock_out(base_clock_out), .timing_interrupt_clock(timing_interrupt_clock),
    .stopped(stopped));

//--- pll_clock_params.svh
// Register offsets, field positions and timing counts
`ifndef PLL_CLOCK_PARAMS_SVH
`define PLL_CLOCK_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_PLL_CONTROL 5'h00
`define OFS_PLL_BANDWIDTH 5'h04
`define OFS_BREAK_FLAG 5'h08
`define OFS_IRQ_STATUS 5'h0c
`define OFS_IRQ_ENABLE 5'h10
`define OFS_IRQ_CLEAR 5'h14
`define ADDR_BITS 5

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_PLL_ON 0
`define CTL_BASE_SEL 1
`define CTL_LOCK_IE 2
`define CTL_LOCK_FLAG 3
`define BW_AUTO 0
`define BW_TRACK 1
`define BW_LOCK 2
`define BFC_ENABLE 0
`define IRQ_LOCK_CHANGE 0
`define IRQ_STOP_FALLBACK 1
`define IRQ_BITS 2

// ****************************************************************
// Measurement windows in reference clock cycles
// ****************************************************************
`define ACQ_WINDOW 16'd32
`define TRK_WINDOW 16'd128
`define MEAS_WIDTH 16

`endif

//--- pll_clock_pkg.sv
// Types shared by the clock control block
package pll_clock_pkg;
    typedef enum logic [1:0] {
        acq_measure,
        trk_measure,
        locked_watch
    } meas_state_t;
endpackage

//--- pll_clock_stop_break_lock.sv
// Clock control: stop handling, break flag protection, lock measurement
//
// Added by the designer: the AXI4-Lite register port and the address map.
`include "pll_clock_params.svh"

// Overview of operation
// - Stop disables generator, holds outputs low
// - Stop clears base clock select bit
// - After stop, crystal half drives base clock
// - Break clears allowed when enable is set
// - Flags cleared in break stay cleared
// - Auto mode sets tracking bit in tolerance
// - Auto mode sets lock bit in tolerance
// - Tracking confirmed over whole reference window
// - Lock confirmed over whole reference window
// - Lock reads zero when auto disabled
// - Tracking bit one tracking, reset acquisition
// - Lock change sets flag and interrupt
// - Select routes vco or crystal half out
module pll_clock_stop_break_lock
    import pll_clock_pkg::*;
#(
    parameter int ACQ_WINDOW = `ACQ_WINDOW,
    parameter int TRK_WINDOW = `TRK_WINDOW
) (
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [`ADDR_BITS-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_BITS-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // System integration
    input wire logic stop_req,
    input wire logic stop_exit,
    input wire logic break_state,
    input wire logic crystal_in,
    input wire logic vco_clock,
    input wire logic ref_tick,
    input wire logic freq_in_trk_tol,
    input wire logic freq_in_lock_tol,
    output logic crystal_clock_out,
    output logic base_clock_out,
    output logic timing_interrupt_clock,
    output logic stopped,
    output logic irq
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic xtal_s, vco_s, tick_s, trk_s, lck_s, stop_s;

    // Pins from outside the domain, except stop_req and break_state, pass two flops before use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {stop_exit, crystal_in, vco_clock, ref_tick,
                      freq_in_trk_tol, freq_in_lock_tol};
            sync2 <= sync1;
        end
    end
    assign {stop_s, xtal_s, vco_s, tick_s, trk_s, lck_s} = sync2;

    logic tick_d, tick_rise;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_d <= 1'b0;
        end else begin
            tick_d <= tick_s;
        end
    end
    assign tick_rise = tick_s & ~tick_d;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic pll_on, base_clock_select, lock_ie, auto_mode, manual_track;
    logic break_flag_clear_enable;
    logic [`IRQ_BITS-1:0] irq_status, irq_enable;
    logic track_mode, lock_ind, lock_change_flag;
    logic stop_mode;

    // Write channel: address and data accepted in either order
    logic aw_held, w_held;
    logic [`ADDR_BITS-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    assign awready = ~aw_held & ~bvalid;
    assign wready = ~w_held & ~bvalid;
    assign wr_go = aw_held & w_held & ~bvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    logic wr_known;
    always_comb begin
        unique case (aw_addr)
            `OFS_PLL_CONTROL, `OFS_PLL_BANDWIDTH, `OFS_BREAK_FLAG,
            `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, `OFS_IRQ_CLEAR: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bresp <= 2'h0;
        end else if (wr_go) begin
            bresp <= wr_known ? 2'h0 : 2'h2;
        end
    end

    logic wr_ctl, wr_bw, wr_bfc, wr_en, wr_clr;
    assign wr_ctl = wr_go && aw_addr == `OFS_PLL_CONTROL && w_strb[0];
    assign wr_bw = wr_go && aw_addr == `OFS_PLL_BANDWIDTH && w_strb[0];
    assign wr_bfc = wr_go && aw_addr == `OFS_BREAK_FLAG && w_strb[0];
    assign wr_en = wr_go && aw_addr == `OFS_IRQ_ENABLE && w_strb[0];
    assign wr_clr = wr_go && aw_addr == `OFS_IRQ_CLEAR && w_strb[0];

    // Control register; select needs pll on, pll cannot drop while selected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pll_on <= 1'b0;
            base_clock_select <= 1'b0;
            lock_ie <= 1'b0;
        end else if (stop_req) begin
            base_clock_select <= 1'b0;
        end else if (wr_ctl && !stop_mode) begin
            pll_on <= w_data[`CTL_PLL_ON] | base_clock_select;
            base_clock_select <= w_data[`CTL_BASE_SEL] & pll_on;
            lock_ie <= w_data[`CTL_LOCK_IE];
        end
    end

    // Bandwidth register; manual tracking value kept while auto
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auto_mode <= 1'b0;
            manual_track <= 1'b0;
        end else if (wr_bw) begin
            auto_mode <= w_data[`BW_AUTO];
            if (!auto_mode) begin
                manual_track <= w_data[`BW_TRACK];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            break_flag_clear_enable <= 1'b0;
        end else if (wr_bfc) begin
            break_flag_clear_enable <= w_data[`BFC_ENABLE];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_enable <= '0;
        end else if (wr_en) begin
            irq_enable <= w_data[`IRQ_BITS-1:0];
        end
    end

    // ****************************************************************
    // Lock measurement
    // ****************************************************************
    meas_state_t meas;
    logic [`MEAS_WIDTH-1:0] meas_cnt;
    logic meas_run, window_end;
    assign meas_run = pll_on & auto_mode & ~stop_mode;
    assign window_end = tick_rise && (meas == acq_measure ?
        meas_cnt == `MEAS_WIDTH'(ACQ_WINDOW - 1) :
        meas_cnt == `MEAS_WIDTH'(TRK_WINDOW - 1));

    // Each window must see tolerance on every reference tick
    logic win_ok;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meas <= acq_measure;
            meas_cnt <= '0;
            win_ok <= 1'b1;
            track_mode <= 1'b0;
            lock_ind <= 1'b0;
        end else if (!meas_run) begin
            meas <= acq_measure;
            meas_cnt <= '0;
            win_ok <= 1'b1;
            track_mode <= 1'b0;
            lock_ind <= 1'b0;
        end else if (tick_rise) begin
            meas_cnt <= window_end ? '0 : meas_cnt + 1'b1;
            win_ok <= window_end ? 1'b1 : win_ok &
                (meas == acq_measure ? trk_s : lck_s);
            if (window_end) begin
                unique case (meas)
                    acq_measure: begin
                        if (win_ok && trk_s) begin
                            meas <= trk_measure;
                            track_mode <= 1'b1;
                        end
                    end
                    trk_measure: begin
                        if (win_ok && lck_s) begin
                            meas <= locked_watch;
                            lock_ind <= 1'b1;
                        end else if (!trk_s) begin
                            meas <= acq_measure;
                            track_mode <= 1'b0;
                        end
                    end
                    locked_watch: begin
                        if (!(win_ok && lck_s)) begin
                            meas <= trk_measure;
                            lock_ind <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    logic lock_d, lock_edge;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock_d <= 1'b0;
        end else begin
            lock_d <= lock_ind;
        end
    end
    assign lock_edge = auto_mode & (lock_ind ^ lock_d);

    // ****************************************************************
    // Flags: set wins over clear; break gates register write clears
    // ****************************************************************
    logic clear_ok;
    assign clear_ok = ~break_state | break_flag_clear_enable;

    // Lock flag clears by writing zero to its control bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock_change_flag <= 1'b0;
        end else if (lock_edge) begin
            lock_change_flag <= 1'b1;
        end else if (!auto_mode) begin
            lock_change_flag <= 1'b0;
        end else if (wr_ctl && clear_ok && !w_data[`CTL_LOCK_FLAG]) begin
            lock_change_flag <= 1'b0;
        end
    end

    logic [`IRQ_BITS-1:0] irq_set;
    assign irq_set = {stop_req & base_clock_select, lock_edge};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
        end else begin
            for (int i = 0; i < `IRQ_BITS; i++) begin
                if (irq_set[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_clr && clear_ok && w_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // Lock interrupt also follows the control register enable
    assign irq = |(irq_status & irq_enable) |
        (lock_change_flag & lock_ie & auto_mode);

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign arready = ~rvalid;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'h0;
            unique case (araddr)
                `OFS_PLL_CONTROL: rdata <= 32'({lock_change_flag & auto_mode,
                    lock_ie, base_clock_select, pll_on});
                `OFS_PLL_BANDWIDTH: rdata <= 32'({lock_ind & auto_mode,
                    auto_mode ? track_mode : manual_track, auto_mode});
                `OFS_BREAK_FLAG: rdata <= 32'(break_flag_clear_enable);
                `OFS_IRQ_STATUS: rdata <= 32'(irq_status);
                `OFS_IRQ_ENABLE: rdata <= 32'(irq_enable);
                `OFS_IRQ_CLEAR: rdata <= 32'h0;
                default: begin
                    rdata <= 32'h0;
                    rresp <= 2'h2;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Stop mode and clock outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stop_mode <= 1'b0;
        end else if (stop_req) begin
            stop_mode <= 1'b1;
        end else if (stop_s) begin
            stop_mode <= 1'b0;
        end
    end
    assign stopped = stop_mode;

    // Outputs registered so the mux never glitches; stop forces all low
    logic xtal_half, vco_half;
    clock_divider u_xtal_div (
        .clk(clk),
        .nrst(nrst),
        .hold(stop_mode | ~xtal_s),
        .half(xtal_half)
    );
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vco_half <= 1'b0;
        end else if (stop_mode || !pll_on) begin
            vco_half <= 1'b0;
        end else if (vco_s) begin
            vco_half <= ~vco_half;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crystal_clock_out <= 1'b0;
            base_clock_out <= 1'b0;
            timing_interrupt_clock <= 1'b0;
        end else if (stop_mode) begin
            crystal_clock_out <= 1'b0;
            base_clock_out <= 1'b0;
            timing_interrupt_clock <= 1'b0;
        end else begin
            crystal_clock_out <= xtal_s;
            base_clock_out <= base_clock_select ? vco_half : xtal_half;
            timing_interrupt_clock <= xtal_s;
        end
    end

endmodule

//--- pll_clock_stop_break_lock_test.sv
// Register-level bench for the clock control block
`include "pll_clock_params.svh"
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module pll_clock_stop_break_lock_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0;
    logic [4:0] awaddr = 5'h0, araddr = 5'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rs, bs;
    logic awready, wready, bvalid, arready, rvalid;
    logic stop_req = 1'b0, stop_exit = 1'b0, break_state = 1'b0, trk_ok = 1'b0;
    logic lock_ok = 1'b0;
    logic crystal_in, vco_clock, ref_tick, trk_tol, lock_tol;
    logic crystal_clock_out, base_clock_out, timing_interrupt_clock, stopped, irq;
    int errors = 0, compares = 0, tog;

    // ****************************************************************
    // Clock, design and far side
    // ****************************************************************
    always #25 clk = ~clk;

    pll_clock_stop_break_lock #(.ACQ_WINDOW(2), .TRK_WINDOW(4)) dut (.clk(clk),
        .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .stop_req(stop_req), .stop_exit(stop_exit),
        .break_state(break_state), .crystal_in(crystal_in), .vco_clock(vco_clock),
        .ref_tick(ref_tick), .freq_in_trk_tol(trk_tol), .freq_in_lock_tol(lock_tol),
        .crystal_clock_out(crystal_clock_out), .base_clock_out(base_clock_out),
        .timing_interrupt_clock(timing_interrupt_clock), .stopped(stopped), .irq(irq));

    pll_far_side_model far (.clk(clk), .nrst(nrst), .trk_ok(trk_ok), .lock_ok(lock_ok),
        .crystal_in(crystal_in), .vco_clock(vco_clock), .ref_tick(ref_tick),
        .freq_in_trk_tol(trk_tol), .freq_in_lock_tol(lock_tol));

    // ****************************************************************
    // Bus tasks; handshakes are judged at the falling edge, where they are settled
    // ****************************************************************
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        int n;
        // Start right after a rising edge, whatever edge the caller stopped on
        @(posedge clk);
        n = 0;
        b_hs = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs && n < 50) begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            bs = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!b_hs) `CHECK(b_hs, 1'b1)
    endtask

    task automatic rdx(input logic [4:0] a);
        logic ar_hs, r_hs;
        int n;
        @(posedge clk);
        n = 0;
        r_hs = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hs && n < 50) begin
            @(negedge clk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            rd = rdata;
            rs = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!r_hs) `CHECK(r_hs, 1'b1)
    endtask

    task automatic count_base(input int cycles);
        logic last;
        last = base_clock_out;
        tog = 0;
        repeat (cycles) begin
            @(negedge clk);
            if (base_clock_out !== last) tog++;
            last = base_clock_out;
        end
        // Hand back on a rising edge so stimulus lands there
        @(posedge clk);
    endtask

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdx(`OFS_PLL_BANDWIDTH); `CHECK(rd, 32'h0)
        rdx(`OFS_BREAK_FLAG); `CHECK(rd, 32'h0)
        rdx(5'h18); `CHECK({rs, rd}, {2'b10, 32'h0})
        wr(5'h18, 32'h0); `CHECK(bs, 2'b10)
        // Tracking reached first, then lock once lock tolerance is met
        wr(`OFS_PLL_BANDWIDTH, 32'h1); `CHECK(bs, 2'b00)
        wr(`OFS_PLL_CONTROL, 32'h1);
        trk_ok <= 1'b1;
        repeat (150) @(posedge clk);
        rdx(`OFS_PLL_BANDWIDTH); `CHECK(rd, 32'h3)
        lock_ok <= 1'b1;
        repeat (150) @(posedge clk);
        rdx(`OFS_PLL_BANDWIDTH); `CHECK(rd, 32'h7)
        rdx(`OFS_IRQ_STATUS); `CHECK(rd, 32'h1)
        `CHECK(irq, 1'b0)
        wr(`OFS_IRQ_ENABLE, 32'h1);
        @(negedge clk); `CHECK(irq, 1'b1)
        wr(`OFS_IRQ_CLEAR, 32'h1);
        @(negedge clk); `CHECK(irq, 1'b0)
        // Flag protection in break, then honoured clear
        @(posedge clk);
        break_state <= 1'b1;
        wr(`OFS_PLL_CONTROL, 32'h1);
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h9)
        wr(`OFS_BREAK_FLAG, 32'h1);
        wr(`OFS_PLL_CONTROL, 32'h1);
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h1)
        break_state <= 1'b0;
        wr(`OFS_BREAK_FLAG, 32'h0);
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h1)
        // Select the VCO only after a long settle
        repeat (400) @(posedge clk);
        wr(`OFS_PLL_CONTROL, 32'h3);
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h3)
        count_base(32); `CHECK(tog > 0, 1'b1)
        // Stop while on the VCO, then recover on the crystal
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        repeat (2) @(negedge clk);
        `CHECK({stopped, crystal_clock_out, base_clock_out, timing_interrupt_clock},
            4'h8)
        count_base(16); `CHECK(tog, 0)
        // Stop drops the loop out of lock, so the lock change flag is set too
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h9)
        rdx(`OFS_IRQ_STATUS); `CHECK(rd, 32'h3)
        stop_exit <= 1'b1;
        tog = 0;
        while (stopped === 1'b1 && tog < 20) begin
            @(posedge clk);
            tog++;
        end
        stop_exit <= 1'b0;
        `CHECK(stopped, 1'b0)
        rdx(`OFS_PLL_CONTROL); `CHECK(rd, 32'h9)
        count_base(32); `CHECK(tog > 0, 1'b1)
        wr(`OFS_PLL_BANDWIDTH, 32'h0);
        rdx(`OFS_PLL_BANDWIDTH); `CHECK(rd, 32'h0)
        test_done();
    end
endmodule

//--- pll_far_side_model.sv
// Behavioural model of crystal, VCO, reference divider and comparators
module pll_far_side_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic trk_ok,
    input wire logic lock_ok,
    output logic crystal_in,
    output logic vco_clock,
    output logic ref_tick,
    output logic freq_in_trk_tol,
    output logic freq_in_lock_tol
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div;

    // Free-running oscillators; a dead crystal is not modelled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= 3'h0;
            crystal_in <= 1'b0;
            vco_clock <= 1'b0;
        end else begin
            div <= div + 3'h1;
            crystal_in <= ~crystal_in;
            vco_clock <= div[0];
        end
    end
    // Reference at one eighth of clk, keeps windows short
    assign ref_tick = div[2];
    // Lock tolerance is tighter, so it never holds without tracking
    assign freq_in_trk_tol = trk_ok;
    assign freq_in_lock_tol = lock_ok & trk_ok;
endmodule
